// [design/mra_bank.sv]
// Result registers, diagnostic flags and alert pin driver of a digital power monitor.
// Assumes the converter and arithmetic core deliver one-cycle strobes on i_sys_clk,
// and that the threshold registers live elsewhere and arrive here as plain values.
// What this block does
// - Die temperature bits 15:4, low nibble zero
// - Current result read-only 16-bit two's complement
// - Power result read-only 24-bit unsigned
// - Transparent mode: alert follows fault clearing
// - Latched mode: alert held until diag read
// - Ready-on-alert puts conversion done on alert
// - Averaged-compare picks averaged or raw values
// - Polarity bit: zero active-low, one active-high
// - Bits 11:10 and 8 read zero
// - Overflow set on overflow, cleared by trigger
// - Temperature over limit sets flag
// - Shunt over limit sets flag
// - Shunt under limit sets flag
// - Bus over limit sets flag
// - Bus under limit sets flag
// - Latched mode: diag read clears limit flags
// - Conversion done set; read/trigger clears in both modes
// - Trim status one unless checksum error
// - Temperature limit compared directly to result
// - Results update only after averaging completes
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
`include "mra_defs.svh"
module mra_bank (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire mra_pkg::mra_addr_t i_addr,
  input wire mra_pkg::mra_word_t i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [23:0] o_rdata,
  // Raw converter samples, one-cycle valid each.
  input wire logic i_raw_valid,
  input wire logic signed [15:0] i_raw_shunt,
  input wire logic [15:0] i_raw_bus,
  input wire logic signed [11:0] i_raw_temp,
  // Completed averaged results with the computed current and power.
  input wire logic i_avg_valid,
  input wire logic signed [15:0] i_avg_shunt,
  input wire logic [15:0] i_avg_bus,
  input wire logic signed [11:0] i_avg_temp,
  input wire logic signed [15:0] i_avg_current,
  input wire logic [23:0] i_avg_power,
  input wire logic i_math_overflow,
  input wire logic i_trigger_start,
  input wire logic i_trim_error,
  // Thresholds from the limit registers.
  input wire logic signed [15:0] i_shunt_over_limit,
  input wire logic signed [15:0] i_shunt_under_limit,
  input wire logic [14:0] i_bus_over_limit,
  input wire logic [14:0] i_bus_under_limit,
  input wire logic signed [11:0] i_temperature_limit_field,
  input wire logic [15:0] i_power_limit,
  output logic o_alert_out,
  output logic o_alert_oe
);
  import mra_pkg::*;

  mra_state_s state_reg;
  mra_state_s state_next;
  logic [5:0] cond;
  logic sample_valid;
  logic signed [15:0] smp_shunt;
  logic [15:0] smp_bus;
  logic signed [11:0] smp_temp;
  logic hold;
  logic diag_read;
  logic alert_active;
  logic [15:0] diag_word;

  always_comb begin
    if (state_reg.ctrl_reg[`MRA_BIT_AVG_CMP - 12]) begin
      sample_valid = i_avg_valid;
      smp_shunt = i_avg_shunt;
      smp_bus = i_avg_bus;
      smp_temp = i_avg_temp;
    end else begin
      sample_valid = i_raw_valid;
      smp_shunt = i_raw_shunt;
      smp_bus = i_raw_bus;
      smp_temp = i_raw_temp;
    end
  end

  // Power limit counts in units of 256 power LSBs, hence the 8-bit shift.
  always_comb begin
    cond[MRA_LIM_TEMP_OVER] = smp_temp > i_temperature_limit_field;
    cond[MRA_LIM_SHUNT_OVER] = smp_shunt > i_shunt_over_limit;
    cond[MRA_LIM_SHUNT_UNDER] = smp_shunt < i_shunt_under_limit;
    cond[MRA_LIM_BUS_OVER] = smp_bus > {1'b0, i_bus_over_limit};
    cond[MRA_LIM_BUS_UNDER] = smp_bus < {1'b0, i_bus_under_limit};
    cond[MRA_LIM_POWER_OVER] = i_avg_power > {i_power_limit, 8'h00};
  end

  assign hold = state_reg.ctrl_reg[`MRA_BIT_HOLD - 12];
  assign diag_read = i_read && (i_addr == `MRA_OFS_DIAG);

  assign diag_word = {state_reg.ctrl_reg, 2'h0, state_reg.overflow_reg, 1'h0,
                      state_reg.limit_reg[0], state_reg.limit_reg[1], state_reg.limit_reg[2],
                      state_reg.limit_reg[3], state_reg.limit_reg[4], state_reg.limit_reg[5],
                      state_reg.conv_done_reg, state_reg.trim_ok_reg};

  always_comb begin
    state_next = state_reg;
    if (i_avg_valid) begin
      state_next.die_temp_reg = i_avg_temp;
      state_next.current_reg = i_avg_current;
      state_next.power_reg = i_avg_power;
    end
    if (i_write && (i_addr == `MRA_OFS_DIAG)) begin
      state_next.ctrl_reg = i_wdata[15:12];
    end
    if (i_avg_valid && i_math_overflow) begin
      state_next.overflow_reg = 1'b1;
    end else if (i_trigger_start) begin
      state_next.overflow_reg = 1'b0;
    end
    // Power is only known after the computation, so its compare waits for the averaged strobe.
    for (int i = 0; i < 6; i++) begin
      if (i == int'(MRA_LIM_POWER_OVER)) begin
        if (i_avg_valid) begin
          if (cond[i]) begin
            state_next.limit_reg[i] = 1'b1;
          end else if (!hold) begin
            state_next.limit_reg[i] = 1'b0;
          end else if (diag_read) begin
            state_next.limit_reg[i] = 1'b0;
          end
        end else if (hold && diag_read) begin
          state_next.limit_reg[i] = 1'b0;
        end
      end else if (sample_valid) begin
        if (cond[i]) begin
          state_next.limit_reg[i] = 1'b1;
        end else if (!hold || diag_read) begin
          state_next.limit_reg[i] = 1'b0;
        end
      end else if (hold && diag_read) begin
        state_next.limit_reg[i] = 1'b0;
      end
    end
    if (i_avg_valid) begin
      state_next.conv_done_reg = 1'b1;
    end else if (i_trigger_start || diag_read) begin
      // Transparent mode drops the flag on the next read or trigger as well.
      state_next.conv_done_reg = 1'b0;
    end
    state_next.trim_ok_reg = !i_trim_error;
    state_next.rdata_reg = 24'h000000;
    if (i_read) begin
      unique case (i_addr)
        `MRA_OFS_DIE_TEMP: state_next.rdata_reg = {8'h00, state_reg.die_temp_reg, 4'h0};
        `MRA_OFS_CURRENT: state_next.rdata_reg = {8'h00, state_reg.current_reg};
        `MRA_OFS_POWER: state_next.rdata_reg = state_reg.power_reg;
        `MRA_OFS_DIAG: state_next.rdata_reg = {8'h00, diag_word};
        default: state_next.rdata_reg = 24'h000000;
      endcase
    end
    alert_active = (|state_next.limit_reg) ||
                   (state_next.conv_done_reg && state_next.ctrl_reg[`MRA_BIT_READY_ALERT - 12]);
    if (state_next.ctrl_reg[`MRA_BIT_POLARITY - 12]) begin
      state_next.alert_oe_reg = 1'b1;
      state_next.alert_out_reg = alert_active;
    end else begin
      state_next.alert_oe_reg = alert_active;
      state_next.alert_out_reg = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_reg <= '0;
      state_reg.trim_ok_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata_reg;
  assign o_alert_out = state_reg.alert_out_reg;
  assign o_alert_oe = state_reg.alert_oe_reg;
endmodule // mra_bank

// [design/mra_defs.svh]
// Offsets, field positions and reset values for the monitor result and alert flag bank.
// Included by the package and the design; holds definitions only.
`ifndef MRA_DEFS_SVH
`define MRA_DEFS_SVH
`define MRA_ADDR_W 6
`define MRA_OFS_DIE_TEMP 6'h06
`define MRA_OFS_CURRENT 6'h07
`define MRA_OFS_POWER 6'h08
`define MRA_OFS_DIAG 6'h0B
`define MRA_DIAG_RESET 16'h0001
`define MRA_DIAG_RW_MASK 16'hF000
`define MRA_BIT_HOLD 15
`define MRA_BIT_READY_ALERT 14
`define MRA_BIT_AVG_CMP 13
`define MRA_BIT_POLARITY 12
`define MRA_BIT_OVERFLOW 9
`define MRA_BIT_TEMP_OVER 7
`define MRA_BIT_SHUNT_OVER 6
`define MRA_BIT_SHUNT_UNDER 5
`define MRA_BIT_BUS_OVER 4
`define MRA_BIT_BUS_UNDER 3
`define MRA_BIT_POWER_OVER 2
`define MRA_BIT_CONV_DONE 1
`define MRA_BIT_TRIM_OK 0
`endif

// [design/mra_pkg.sv]
// Types shared by the monitor result and alert flag bank.
// Assumes mra_defs.svh is on the include path.
`include "mra_defs.svh"
package mra_pkg;
  typedef logic [`MRA_ADDR_W-1:0] mra_addr_t;
  typedef logic [15:0] mra_word_t;
  // Order of the six limit flags, bit 7 down to bit 2.
  typedef enum logic [2:0] {
    MRA_LIM_TEMP_OVER = 3'h0,
    MRA_LIM_SHUNT_OVER = 3'h1,
    MRA_LIM_SHUNT_UNDER = 3'h2,
    MRA_LIM_BUS_OVER = 3'h3,
    MRA_LIM_BUS_UNDER = 3'h4,
    MRA_LIM_POWER_OVER = 3'h5
  } mra_limit_e;
  typedef struct packed {
    logic [11:0] die_temp_reg;
    logic [15:0] current_reg;
    logic [23:0] power_reg;
    logic [3:0] ctrl_reg;
    logic overflow_reg;
    logic [5:0] limit_reg;
    logic conv_done_reg;
    logic trim_ok_reg;
    logic [23:0] rdata_reg;
    logic alert_oe_reg;
    logic alert_out_reg;
  } mra_state_s;
endpackage

// [dv/mra_bank_bench.sv]
// Bench for the result and flag bank.
// Assumes the checker binds itself; thresholds are fixed except the temperature limit tl.
`timescale 1ns/1ns
module mra_bank_bench;
  import mra_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, rv = 0, av = 0, ovf = 0, trg = 0, terr = 0, hen = 0, power_over_flag = 0;
  logic h_rd, ao, aoe;
  mra_addr_t addr = 6'h00;
  mra_word_t wd = 16'h0;
  logic [23:0] rdata, ap = 24'h0;
  logic signed [15:0] sh = 16'h0, ac = 16'h0;
  logic [15:0] ab = 16'h2000;
  logic signed [11:0] at = 12'h0, tl = 12'h7FF;
  int miscompares = 0, n_tests = 0, cyc = 0;
  mra_bank i_mra_bank (.i_sys_clk(clk), .i_reset(rst), .i_addr(h_rd ? 6'h0B : addr), .i_wdata(wd), .i_write(wr),
    .i_read(rd | h_rd), .o_rdata(rdata), .i_raw_valid(rv), .i_raw_shunt(sh), .i_raw_bus(ab), .i_raw_temp(at),
    .i_avg_valid(av), .i_avg_shunt(sh), .i_avg_bus(ab), .i_avg_temp(at), .i_avg_current(ac), .i_avg_power(ap),
    .i_math_overflow(ovf), .i_trigger_start(trg), .i_trim_error(terr), .i_shunt_over_limit(16'h1000),
    .i_shunt_under_limit(16'hF000), .i_bus_over_limit(15'h4000), .i_bus_under_limit(15'h0100),
    .i_temperature_limit_field(tl), .i_power_limit(16'h0100), .o_alert_out(ao), .o_alert_oe(aoe));
  mra_host i_host (.i_sys_clk(clk), .i_en(hen), .i_pol(power_over_flag), .i_alert_out(ao), .i_alert_oe(aoe), .o_read(h_rd));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  function automatic logic [23:0] dg(input logic [3:0] c, input logic [7:0] f);
    return {8'h00, c, 4'h0, f};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrt(input logic [5:0] a, input logic [15:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdx(input logic [5:0] a, input logic [23:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, e);
    @(posedge clk);
  endtask
  task automatic idle(input logic e);
    @(negedge clk);
    chk("alert", power_over_flag ? (aoe ? ao : 1'b1) : !(aoe ? ao : 1'b1), e);
    @(posedge clk);
  endtask
  task automatic ev(input logic averaging_count_select, input logic e);
    av <= averaging_count_select;
    rv <= !averaging_count_select;
    @(posedge clk);
    av <= 1'b0;
    rv <= 1'b0;
    idle(e);
  endtask
  initial begin
    void'($urandom(32'hA20B7EE1));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wrt(6'h07, 16'hFFFF);
    for (int a = 5; a < 12; a++) rdx(6'(a), a == 11 ? 24'h1 : 24'h0);
    $display("test reset end");
    for (int i = 0; i < 4; i++) begin
      sh <= 16'($urandom_range(4095));
      ac <= 16'($urandom());
      at <= 12'($urandom());
      ab <= 16'(16'h0100 + $urandom_range(16'h3F00));
      ap <= 24'($urandom_range(24'h00FFFF));
      ev(1'b1, 1'b0);
      rdx(6'h0B, dg(4'h0, 8'h03));
      rdx(6'h06, {8'h00, at, 4'h0});
      rdx(6'h07, {8'h00, ac});
      rdx(6'h08, ap);
    end
    $display("test results end");
    sh <= 16'h1001;
    ev(1'b0, 1'b1);
    sh <= 16'h0;
    ev(1'b0, 1'b0);
    rdx(6'h0B, dg(4'h0, 8'h01));
    $display("test transparent end");
    tl <= 12'(12'h001 + $urandom_range(1000));
    for (int k = 0; k < 6; k++) begin
      power_over_flag <= k[0];
      wrt(6'h0B, {3'h5, k[0], 12'hFFF});
      sh <= k == 1 ? 16'h1001 : k == 2 ? 16'hEFFF : 16'h0;
      at <= k == 0 ? tl + 12'h1 : 12'h0;
      ab <= k == 3 ? 16'h4001 : k == 4 ? 16'h00FF : 16'h2000;
      ap <= k == 5 ? 24'h010001 : 24'h0;
      ev(1'b0, 1'b0);
      ev(1'b1, 1'b1);
      rdx(6'h0B, dg({3'h5, k[0]}, (8'h80 >> k) | 8'h03));
      idle(1'b0);
      rdx(6'h0B, dg({3'h5, k[0]}, 8'h01));
    end
    $display("test latched end");
    power_over_flag <= 1'b0;
    ap <= 24'h0;
    wrt(6'h0B, 16'h4000);
    ovf <= 1'b1;
    ev(1'b1, 1'b1);
    ovf <= 1'b0;
    rdx(6'h0B, dg(4'h4, 8'h03) | 24'h200);
    ev(1'b1, 1'b1);
    trg <= 1'b1;
    @(posedge clk);
    trg <= 1'b0;
    idle(1'b0);
    rdx(6'h0B, dg(4'h4, 8'h01));
    terr <= 1'b1;
    @(posedge clk);
    rdx(6'h0B, dg(4'h4, 8'h00));
    terr <= 1'b0;
    $display("test overflow end");
    power_over_flag <= 1'b1;
    wrt(6'h0B, 16'h9000);
    sh <= 16'h1001;
    ev(1'b0, 1'b1);
    sh <= 16'h0;
    ev(1'b0, 1'b1);
    hen <= 1'b1;
    repeat (4) @(posedge clk);
    hen <= 1'b0;
    idle(1'b0);
    $display("test host end");
    report_and_stop();
  end
endmodule // mra_bank_bench

// [dv/mra_bank_chk.sv]
// Port checker for the result and flag bank.
// Assumes control bits change only by writes to the flag register.
`timescale 1ns/1ns
module mra_bank_chk (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire mra_pkg::mra_addr_t i_addr,
  input wire mra_pkg::mra_word_t i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [23:0] o_rdata,
  input wire logic i_avg_valid,
  input wire logic [23:0] i_avg_power,
  input wire logic i_math_overflow,
  input wire logic i_trigger_start,
  input wire logic o_alert_out,
  input wire logic o_alert_oe
);
  import mra_pkg::*;
  logic [3:0] ctl;
  logic [23:0] pw;
  logic rdd;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  assign rdd = i_read && i_addr == 6'h0B;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ctl <= 4'h0;
      pw <= 24'h0;
    end else begin
      if (i_write && i_addr == 6'h0B) ctl <= i_wdata[15:12];
      if (i_avg_valid) pw <= i_avg_power;
    end
  end
  sequence s_done;
    i_avg_valid && !i_trigger_start ##1 !i_read && !i_trigger_start ##1 rdd;
  endsequence
  sequence s_ovf;
    i_avg_valid && i_math_overflow ##1 !i_trigger_start ##1 rdd;
  endsequence
  sequence s_quiet;
    rdd && ctl[3:1] == 3'h5 && !i_avg_valid ##1 !i_avg_valid;
  endsequence
  a_temp_nibble: assert property (i_read && i_addr == 6'h06 |=> o_rdata[3:0] == 4'h0)
    else $error("temperature low nibble set");
  a_power_load: assert property (i_read && i_addr == 6'h08 |=> o_rdata == $past(pw))
    else $error("power result wrong");
  a_diag_zeros: assert property (rdd |=> o_rdata[11:10] == 2'h0 && !o_rdata[8])
    else $error("reserved flag bits set");
  a_ovf_set: assert property (s_ovf |=> o_rdata[9])
    else $error("overflow flag missing");
  a_done_set: assert property (s_done |=> o_rdata[1])
    else $error("conversion done missing");
  a_pol_high: assert property (ctl[0] && $past(ctl[0]) |-> o_alert_oe)
    else $error("active-high pin not driven");
  a_pol_low: assert property (!ctl[0] && !$past(ctl[0]) |-> !o_alert_out)
    else $error("active-low pin drives high");
  a_latch_release: assert property (s_quiet |-> !(ctl[0] ? o_alert_out : o_alert_oe))
    else $error("alert held after read");
endmodule // mra_bank_chk
bind mra_bank mra_bank_chk i_chk (.i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata,
  .i_avg_valid, .i_avg_power, .i_math_overflow, .i_trigger_start, .o_alert_out, .o_alert_oe);

// [dv/mra_host.sv]
// Host model: reads the flag register while the alert pin is active.
// Assumes a pull-up on the alert wire.
`timescale 1ns/1ns
module mra_host (
  input wire logic i_sys_clk,
  input wire logic i_en,
  input wire logic i_pol,
  input wire logic i_alert_out,
  input wire logic i_alert_oe,
  output logic o_read
);
  initial o_read = 1'b0;
  always @(posedge i_sys_clk) o_read <= i_en && !o_read && (i_alert_oe ? i_alert_out : 1'b1) == i_pol;
endmodule // mra_host
